/* logic/bmcr_pkg.sv */
// package of offsets, field positions and reset values for the misc config registers
`default_nettype none
package bmcr_pkg;
    // register byte addresses
    localparam logic [7:0] BMCR_OFF_TEST_ONE   = 8'hBC;
    localparam logic [7:0] BMCR_OFF_TEST_TWO   = 8'hC0;
    localparam logic [7:0] BMCR_OFF_TEST_THREE = 8'hC4;
    localparam logic [7:0] BMCR_OFF_STRAP      = 8'hC8;
    localparam logic [7:0] BMCR_OFF_PIN_IO     = 8'hD8;
    localparam logic [7:0] BMCR_OFF_EEPROM     = 8'hDC;
    localparam logic [7:0] BMCR_OFF_CAP        = 8'hE0;
    localparam logic [7:0] BMCR_OFF_AUTOLOAD   = 8'hF0;
    // reset values
    localparam logic [31:0] BMCR_TEST_RESET = 32'h0000_0000;
    localparam logic [7:0]  BMCR_CAP_ID     = 8'h10;
    localparam logic [7:0]  BMCR_CAP_NEXT   = 8'h00;
    localparam logic [3:0]  BMCR_CAP_VER    = 4'h1;
    localparam logic [3:0]  BMCR_PORT_TYPE  = 4'h1;
    localparam logic [31:0] BMCR_CAP_WORD   =
        {2'h0, 5'h00, 1'h0, BMCR_PORT_TYPE, BMCR_CAP_VER, BMCR_CAP_NEXT, BMCR_CAP_ID};
    // pin io control field positions
    localparam int BMCR_PIO_IN_LSB  = 0;
    localparam int BMCR_PIO_DIR_LSB = 8;
    localparam int BMCR_PIO_OUT_LSB = 16;
    // eeprom command field positions and codes
    localparam int BMCR_EE_START    = 0;
    localparam int BMCR_EE_PRELOAD  = 2;
    localparam int BMCR_EE_CMD_LSB  = 3;
    localparam int BMCR_EE_ADDR_LSB = 5;
    localparam int BMCR_EE_DATA_LSB = 16;
    localparam logic [1:0] BMCR_CMD_WRITE = 2'h1;
    localparam logic [1:0] BMCR_CMD_READ  = 2'h2;
    // AXI responses
    localparam logic [1:0] BMCR_RESP_OKAY   = 2'h0;
    localparam logic [1:0] BMCR_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* logic/bmcr_regs.sv */
// AXI4-Lite register bank for the bridge misc configuration registers
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module bmcr_regs
    import bmcr_pkg::*;
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // AXI4-Lite write address and data
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    // strap pins
    input  wire logic        low_drive_strap_i,
    input  wire logic        high_drive_strap_i,
    input  wire logic [3:0]  tx_current_strap_i,
    input  wire logic [3:0]  deemphasis_strap_i,
    input  wire logic [1:0]  rx_termination_strap_i,
    input  wire logic [1:0]  tx_termination_strap_i,
    // eeprom autoload of strap values
    input  wire logic        autoload_valid_i,
    input  wire logic [13:0] autoload_strap_i,
    // general purpose pins
    input  wire logic [7:0]  pin_i,
    output logic [7:0]       pin_o,
    output logic [7:0]       pin_oe_o,
    // eeprom engine
    output logic             ee_start_o,
    output logic             ee_preload_o,
    output logic [1:0]       ee_cmd_o,
    output logic [10:0]      ee_addr_o,
    output logic [15:0]      ee_wdata_o,
    input  wire logic        ee_done_i
);

    typedef struct packed {
        logic [7:0]  pin_meta;
        logic [7:0]  pin_sync;
        logic [13:0] strap_meta;
        logic [13:0] strap_sync;
        logic [13:0] strap;
        logic        strap_loaded;
        logic [7:0]  pin_dir;
        logic [7:0]  pin_out;
        logic        ee_start;
        logic        ee_preload;
        logic [1:0]  ee_cmd;
        logic [10:0] ee_addr;
        logic [15:0] ee_wdata;
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } bmcr_state_t;

    bmcr_state_t state;
    bmcr_state_t next_state;

    // byte-lane merge of write data
    function automatic logic [31:0] bmcr_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // true for any mapped word
    function automatic logic bmcr_mapped(input logic [7:0] a);
        case (a)
            BMCR_OFF_TEST_ONE, BMCR_OFF_TEST_TWO, BMCR_OFF_TEST_THREE,
            BMCR_OFF_STRAP, BMCR_OFF_PIN_IO, BMCR_OFF_EEPROM, BMCR_OFF_CAP: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    logic [13:0] strap_pins;
    logic [31:0] pio_word;
    logic [31:0] ee_word;
    logic [31:0] rd_word;
    logic [31:0] wr_merged;
    logic        do_write;
    logic        do_read;
    logic [7:0]  wr_addr;

    assign strap_pins = {tx_termination_strap_i, rx_termination_strap_i, deemphasis_strap_i,
                         tx_current_strap_i, high_drive_strap_i, low_drive_strap_i};
    assign pio_word   = {8'h00, state.pin_out, state.pin_dir, state.pin_sync};
    assign ee_word    = {state.ee_wdata, state.ee_addr, state.ee_cmd, state.ee_preload,
                         1'b0, state.ee_start};
    assign wr_addr    = s_axi_awvalid_i && !state.aw_held ? s_axi_awaddr_i : state.aw_addr;

    // read data mux
    always_comb begin
        case (s_axi_araddr_i)
            BMCR_OFF_TEST_ONE:   rd_word = BMCR_TEST_RESET;
            BMCR_OFF_TEST_TWO:   rd_word = BMCR_TEST_RESET;
            BMCR_OFF_TEST_THREE: rd_word = BMCR_TEST_RESET;
            BMCR_OFF_STRAP:      rd_word = {18'h00000, state.strap};
            BMCR_OFF_PIN_IO:     rd_word = pio_word;
            BMCR_OFF_EEPROM:     rd_word = ee_word;
            BMCR_OFF_CAP:        rd_word = BMCR_CAP_WORD;
            default:             rd_word = 32'h0000_0000;
        endcase
    end

    // write fires once both address and data are present
    assign do_write  = (state.aw_held || s_axi_awvalid_i) && (state.w_held || s_axi_wvalid_i)
                       && !state.bvalid;
    assign do_read   = s_axi_arvalid_i && !state.rvalid;
    assign wr_merged = bmcr_merge(wr_addr == BMCR_OFF_PIN_IO ? pio_word : ee_word,
                                  state.w_held ? state.w_data : s_axi_wdata_i,
                                  state.w_held ? state.w_strb : s_axi_wstrb_i);

    // handshake outputs
    assign s_axi_awready_o = !state.aw_held && !state.bvalid;
    assign s_axi_wready_o  = !state.w_held && !state.bvalid;
    assign s_axi_arready_o = !state.rvalid;
    assign s_axi_bvalid_o  = state.bvalid;
    assign s_axi_bresp_o   = state.bresp;
    assign s_axi_rvalid_o  = state.rvalid;
    assign s_axi_rdata_o   = state.rdata;
    assign s_axi_rresp_o   = state.rresp;

    // pin drive and eeprom outputs
    assign pin_o        = state.pin_out;
    assign pin_oe_o     = state.pin_dir;
    assign ee_start_o   = state.ee_start;
    assign ee_preload_o = state.ee_preload;
    assign ee_cmd_o     = state.ee_cmd;
    assign ee_addr_o    = state.ee_addr;
    assign ee_wdata_o   = state.ee_wdata;

    // next-state logic
    always_comb begin
        next_state = state;
        next_state.pin_meta = pin_i;
        next_state.pin_sync = state.pin_meta;
        // strap pins pass two flops like the other pins
        next_state.strap_meta = strap_pins;
        next_state.strap_sync = state.strap_meta;
        // straps follow pins until an autoload replaces them
        if (autoload_valid_i) begin
            next_state.strap        = autoload_strap_i;
            next_state.strap_loaded = 1'b1;
        end else if (!state.strap_loaded) begin
            next_state.strap = state.strap_sync;
        end
        // capture write channels
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            next_state.w_held = 1'b1;
            next_state.w_data = s_axi_wdata_i;
            next_state.w_strb = s_axi_wstrb_i;
        end
        // engine completion clears start and preload
        if (ee_done_i) begin
            next_state.ee_start   = 1'b0;
            next_state.ee_preload = 1'b0;
        end
        if (do_write) begin
            next_state.aw_held = 1'b0;
            next_state.w_held  = 1'b0;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = bmcr_mapped(wr_addr) ? BMCR_RESP_OKAY : BMCR_RESP_SLVERR;
            if (wr_addr == BMCR_OFF_PIN_IO) begin
                next_state.pin_dir = wr_merged[BMCR_PIO_DIR_LSB +: 8];
                next_state.pin_out = wr_merged[BMCR_PIO_OUT_LSB +: 8];
            end
            if (wr_addr == BMCR_OFF_EEPROM) begin
                // a fresh start wins over a completion in the same cycle
                next_state.ee_start   = wr_merged[BMCR_EE_START] | next_state.ee_start;
                next_state.ee_preload = wr_merged[BMCR_EE_PRELOAD] | next_state.ee_preload;
                next_state.ee_cmd     = wr_merged[BMCR_EE_CMD_LSB +: 2];
                next_state.ee_addr    = wr_merged[BMCR_EE_ADDR_LSB +: 11];
                next_state.ee_wdata   = wr_merged[BMCR_EE_DATA_LSB +: 16];
            end
        end
        if (state.bvalid && s_axi_bready_i) begin
            next_state.bvalid = 1'b0;
        end
        if (do_read) begin
            next_state.rvalid = 1'b1;
            next_state.rdata  = rd_word;
            next_state.rresp  = bmcr_mapped(s_axi_araddr_i) ? BMCR_RESP_OKAY : BMCR_RESP_SLVERR;
        end else if (state.rvalid && s_axi_rready_i) begin
            next_state.rvalid = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // test word two always reads zero
    property p_test_zero;
        @(posedge clock_i) disable iff (!rst_n_i)
        (do_read && s_axi_araddr_i == BMCR_OFF_TEST_TWO) |=> (s_axi_rdata_o == 32'h0);
    endproperty
    a_test_zero: assert property (p_test_zero) else $error("test word not zero");

    // strap reserved bits zero
    property p_strap_rsvd;
        @(posedge clock_i) disable iff (!rst_n_i)
        (do_read && s_axi_araddr_i == BMCR_OFF_STRAP) |=> (s_axi_rdata_o[31:14] == 18'h0);
    endproperty
    a_strap_rsvd: assert property (p_strap_rsvd) else $error("strap reserved set");

    // autoload value appears in strap register
    property p_autoload;
        @(posedge clock_i) disable iff (!rst_n_i)
        autoload_valid_i |=> (state.strap == $past(autoload_strap_i));
    endproperty
    a_autoload: assert property (p_autoload) else $error("autoload not taken");

    // capability word fixed
    property p_cap;
        @(posedge clock_i) disable iff (!rst_n_i)
        (do_read && s_axi_araddr_i == BMCR_OFF_CAP) |=> (s_axi_rdata_o == 32'h0011_0010);
    endproperty
    a_cap: assert property (p_cap) else $error("capability word wrong");

    // enable follows direction bits
    property p_dir;
        @(posedge clock_i) disable iff (!rst_n_i)
        (do_write && wr_addr == BMCR_OFF_PIN_IO && (state.w_held ? state.w_strb[1]
            : s_axi_wstrb_i[1])) |=> (pin_oe_o == $past(wr_merged[15:8]));
    endproperty
    a_dir: assert property (p_dir) else $error("direction not applied");

    // start stays until done
    sequence s_started;
        ee_start_o && !ee_done_i;
    endsequence
    property p_start_hold;
        @(posedge clock_i) disable iff (!rst_n_i)
        s_started |=> ee_start_o;
    endproperty
    a_start_hold: assert property (p_start_hold) else $error("start dropped early");

    // done clears start unless rewritten
    property p_start_clear;
        @(posedge clock_i) disable iff (!rst_n_i)
        (ee_done_i && !(do_write && wr_addr == BMCR_OFF_EEPROM)) |=> !ee_start_o;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("start not cleared");

    // write answered one cycle after both channels present
    property p_bresp;
        @(posedge clock_i) disable iff (!rst_n_i)
        do_write |=> s_axi_bvalid_o;
    endproperty
    a_bresp: assert property (p_bresp) else $error("write response lost");

    // straps track the synchronised pins until an autoload
    property p_strap_follow;
        @(posedge clock_i) disable iff (!rst_n_i)
        (!state.strap_loaded && !autoload_valid_i)
            |=> (state.strap == $past(state.strap_sync));
    endproperty
    a_strap_follow: assert property (p_strap_follow) else $error("strap stale");

    // strap word shows the held strap fields
    property p_strap_read;
        @(posedge clock_i) disable iff (!rst_n_i)
        (do_read && s_axi_araddr_i == BMCR_OFF_STRAP)
            |=> (s_axi_rdata_o[13:0] == $past(state.strap));
    endproperty
    a_strap_read: assert property (p_strap_read) else $error("strap fields wrong");

    // pin word low byte shows synchronised pin levels
    property p_pin_read;
        @(posedge clock_i) disable iff (!rst_n_i)
        (do_read && s_axi_araddr_i == BMCR_OFF_PIN_IO)
            |=> (s_axi_rdata_o[7:0] == $past(state.pin_sync));
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin levels wrong");

    // pin drive level follows the written lane
    property p_pin_level;
        @(posedge clock_i) disable iff (!rst_n_i)
        (do_write && wr_addr == BMCR_OFF_PIN_IO)
            |=> (pin_o == $past(wr_merged[BMCR_PIO_OUT_LSB +: 8]));
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("drive level not applied");

    // pin word top byte reads zero
    property p_pin_rsvd;
        @(posedge clock_i) disable iff (!rst_n_i)
        (do_read && s_axi_araddr_i == BMCR_OFF_PIN_IO) |=> (s_axi_rdata_o[31:24] == 8'h00);
    endproperty
    a_pin_rsvd: assert property (p_pin_rsvd) else $error("pin reserved set");

    // written preload bit raises the preload request
    property p_preload;
        @(posedge clock_i) disable iff (!rst_n_i)
        (do_write && wr_addr == BMCR_OFF_EEPROM && wr_merged[BMCR_EE_PRELOAD]) |=> ee_preload_o;
    endproperty
    a_preload: assert property (p_preload) else $error("preload not raised");

    // command, address and data fields take the written word
    property p_ee_fields;
        @(posedge clock_i) disable iff (!rst_n_i)
        (do_write && wr_addr == BMCR_OFF_EEPROM)
            |=> ({ee_wdata_o, ee_addr_o, ee_cmd_o} == $past(wr_merged[31:BMCR_EE_CMD_LSB]));
    endproperty
    a_ee_fields: assert property (p_ee_fields) else $error("eeprom fields wrong");

    // reserved bit 1 of the eeprom word reads zero
    property p_ee_rsvd;
        @(posedge clock_i) disable iff (!rst_n_i)
        (do_read && s_axi_araddr_i == BMCR_OFF_EEPROM) |=> !s_axi_rdata_o[1];
    endproperty
    a_ee_rsvd: assert property (p_ee_rsvd) else $error("eeprom reserved set");

endmodule
`default_nettype wire

/* tb/bmcr_ee_model.sv */
// eeprom engine stand-in answering start or preload with a done pulse
`timescale 1ns/100ps
`default_nettype none
module bmcr_ee_model (
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    // request side
    input  wire logic       ee_start_i,
    input  wire logic       ee_preload_i,
    input  wire logic [7:0] delay_i,
    // completion
    output logic            ee_done_o
);
    logic [7:0] cnt;
    // count down the access time, then pulse done once
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt       <= 8'h00;
            ee_done_o <= 1'b0;
        end else begin
            ee_done_o <= 1'b0;
            if (cnt == 8'h01) begin
                ee_done_o <= 1'b1;
                cnt       <= 8'h00;
            end else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end else if ((ee_start_i || ee_preload_i) && !ee_done_o) begin
                cnt <= delay_i;
            end
        end
    end
endmodule
`default_nettype wire

/* tb/bmcr_regs_bench.sv */
// self-checking bench for the misc configuration register bank
`timescale 1ns/100ps
`default_nettype none
module bmcr_regs_bench
    import bmcr_pkg::*;
;
    logic        clock_i, rst_n_i, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, lo, hi, al_valid;
    logic [7:0]  awaddr, araddr, ext, pin_in, pin_out, pin_oe, ee_delay;
    logic [31:0] wdata, rdata;
    logic [3:0]  cur, de, strb;
    logic [1:0]  bresp, rresp, rx, tx, ee_cmd;
    logic [13:0] al_strap;
    logic        ee_start, ee_pre, ee_done;
    logic [10:0] ee_addr;
    logic [15:0] ee_wdata;
    int          failures = 0;
    int          tests_run = 0;
    int          cycles = 0;
    // resolved pin level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
    bmcr_regs u_bmcr_regs (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .low_drive_strap_i(lo),
        .high_drive_strap_i(hi), .tx_current_strap_i(cur), .deemphasis_strap_i(de),
        .rx_termination_strap_i(rx), .tx_termination_strap_i(tx),
        .autoload_valid_i(al_valid), .autoload_strap_i(al_strap), .pin_i(pin_in),
        .pin_o(pin_out), .pin_oe_o(pin_oe), .ee_start_o(ee_start), .ee_preload_o(ee_pre),
        .ee_cmd_o(ee_cmd), .ee_addr_o(ee_addr), .ee_wdata_o(ee_wdata), .ee_done_i(ee_done));
    bmcr_ee_model u_bmcr_ee_model (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .ee_start_i(ee_start), .ee_preload_i(ee_pre), .delay_i(ee_delay),
        .ee_done_o(ee_done));
    // compare and count
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // bus write, response code compared
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clock_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk("write response", {30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        @(posedge clock_i);
    endtask
    // bus read
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clock_i);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
                          input string nm);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(nm, d, ed);
        chk("read response", {30'h0, r}, {30'h0, er});
    endtask
    task automatic t_reset_values();
        rd_chk(BMCR_OFF_TEST_ONE, 32'h0, BMCR_RESP_OKAY, "test word one");
        rd_chk(BMCR_OFF_TEST_THREE, 32'h0, BMCR_RESP_OKAY, "test word three");
        rd_chk(BMCR_OFF_EEPROM, 32'h0, BMCR_RESP_OKAY, "eeprom reset");
        wr(BMCR_OFF_TEST_TWO, 32'hFFFF_FFFF, BMCR_RESP_OKAY);
        wr(BMCR_OFF_CAP, 32'hFFFF_FFFF, BMCR_RESP_OKAY);
        rd_chk(BMCR_OFF_TEST_TWO, 32'h0, BMCR_RESP_OKAY, "test word two");
        rd_chk(BMCR_OFF_CAP, 32'h0011_0010, BMCR_RESP_OKAY, "cap word");
        rd_chk(8'hCC, 32'h0, BMCR_RESP_SLVERR, "unmapped read");
        wr(8'hCC, 32'h1234_5678, BMCR_RESP_SLVERR);
        $display("test reset values done");
    endtask
    task automatic t_straps();
        rd_chk(BMCR_OFF_STRAP, {18'h0, tx, rx, de, cur, hi, lo}, BMCR_RESP_OKAY,
               "straps");
        lo  <= 1'b0;
        hi  <= 1'b1;
        cur <= 4'h5;
        de  <= 4'hA;
        rx  <= 2'h1;
        tx  <= 2'h2;
        repeat (3) @(posedge clock_i);
        rd_chk(BMCR_OFF_STRAP, 32'h0000_2696, BMCR_RESP_OKAY, "straps moved");
        al_strap <= 14'h2C3A;
        al_valid <= 1'b1;
        @(posedge clock_i);
        al_valid <= 1'b0;
        cur      <= 4'hF;
        repeat (3) @(posedge clock_i);
        rd_chk(BMCR_OFF_STRAP, 32'h0000_2C3A, BMCR_RESP_OKAY, "autoload");
        $display("test straps done");
    endtask
    task automatic t_pins();
        ext <= 8'h3C;
        repeat (3) @(posedge clock_i);
        rd_chk(BMCR_OFF_PIN_IO, 32'h0000_003C, BMCR_RESP_OKAY, "pins in");
        wr(BMCR_OFF_PIN_IO, 32'hFFA5_0F00, BMCR_RESP_OKAY);
        chk("pin enable", {24'h0, pin_oe}, 32'h0000_000F);
        chk("pin level", {24'h0, pin_out}, 32'h0000_00A5);
        repeat (3) @(posedge clock_i);
        rd_chk(BMCR_OFF_PIN_IO, 32'h00A5_0F35, BMCR_RESP_OKAY, "pins mixed");
        // only byte lane 2 enabled: direction must stay
        strb <= 4'h4;
        wr(BMCR_OFF_PIN_IO, 32'h005A_FFFF, BMCR_RESP_OKAY);
        strb <= 4'hF;
        chk("pin level lane", {24'h0, pin_out}, 32'h0000_005A);
        chk("pin enable kept", {24'h0, pin_oe}, 32'h0000_000F);
        $display("test pins done");
    endtask
    task automatic t_eeprom();
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        ee_delay <= 8'h14;
        wr(BMCR_OFF_EEPROM, 32'hBEEF_FFEB, BMCR_RESP_OKAY);
        chk("start", {31'h0, ee_start}, 32'h1);
        chk("cmd", {30'h0, ee_cmd}, {30'h0, BMCR_CMD_WRITE});
        chk("addr", {21'h0, ee_addr}, 32'h0000_07FF);
        chk("wdata", {16'h0, ee_wdata}, 32'h0000_BEEF);
        rd_chk(BMCR_OFF_EEPROM, 32'hBEEF_FFE9, BMCR_RESP_OKAY, "eeprom busy");
        n = 0;
        do begin
            rd(BMCR_OFF_EEPROM, d, r);
            n++;
        end while (d[0] !== 1'b0 && n < 40);
        chk("eeprom write done", d, 32'hBEEF_FFE8);
        ee_delay <= 8'h01;
        wr(BMCR_OFF_EEPROM, 32'h1234_0034, BMCR_RESP_OKAY);
        chk("preload", {31'h0, ee_pre}, 32'h1);
        chk("read cmd", {30'h0, ee_cmd}, {30'h0, BMCR_CMD_READ});
        repeat (4) @(posedge clock_i);
        rd_chk(BMCR_OFF_EEPROM, 32'h1234_0030, BMCR_RESP_OKAY, "preload done");
        $display("test eeprom done");
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // clock
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    // hang guard
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            test_done();
        end
    end
    // main sequence
    initial begin
        {rst_n_i, awvalid, wvalid, bready, arvalid, rready, al_valid} = 7'h00;
        {awaddr, araddr, wdata, al_strap, ee_delay} = 70'h0;
        {lo, hi, cur, de, rx, tx} = 14'h1969;
        ext = 8'h00;
        strb = 4'hF;
        repeat (20) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        t_reset_values();
        t_straps();
        t_pins();
        t_eeprom();
        test_done();
    end
endmodule
`default_nettype wire
